/* design/usb_in_ep_cfg.svh */
// constants for the endpoint descriptor block
// Operation
// [R1] in byte count 0..64, above is illegal
// [R2] ready flag 0 sends, 1 answers NAK
// [R3] y base gives address bits 10..3
// [R4] transaction starts at descriptor base address
// [R5] buffer manager never alters base fields
// [R6] one size field for X and Y
// [R7] ep0 buffers fixed at FEF8 and FEF0
// [R8] ep0 in config FF80, count FF81
// [R9] ep0 out config FF82, count FF83
// [R10] interrupt enable gates completion interrupt
// [R11] stall bit answers requests with STALL
// [R12] next SETUP clears ep0 in stall
// [R13] ep0 toggle is read only, shows DATA0/1
// [R14] disabled endpoint ignored by buffer manager
// [R15] software writes y base before enabling
// [R16] reserved bits read zero, config resets zero
// [R17] double buffer: toggle picks X or Y
// [R18] ep0 in ready flag resets to empty
// [R19] out ready flag 1 means packet held
// [R20] acknowledged in packet marks buffer empty
// [R21] software writes count and flag together
`ifndef USB_IN_EP_CFG_SVH
`define USB_IN_EP_CFG_SVH
`define APB_AW 18
`define EP0_IN_CFG_IDX 16'hff80
`define EP0_IN_CNT_IDX 16'hff81
`define EP0_OUT_CFG_IDX 16'hff82
`define EP0_OUT_CNT_IDX 16'hff83
`define EPN_PAGE 11'h002
`define OFS_X_BASE 3'h0
`define OFS_X_CNT 3'h1
`define OFS_Y_BASE 3'h2
`define OFS_Y_CNT 3'h3
`define OFS_SIZE 3'h4
`define OFS_CFG 3'h5
`define BIT_EN 7
`define BIT_TOG 5
`define BIT_DOUBLE_BUFFER_ENABLE 4
`define BIT_STALL 3
`define BIT_IE 2
`define BIT_NAK 7
`define CFG_RST 8'h00
`define CNT_RST 8'h80
`define EP0_CFG_WMASK 8'h8c
`define EP0_CNT_WMASK 8'h8f
`define EPN_CFG_WMASK 8'hbc
`define SIZE_WMASK 8'h7f
`define EP0_IN_BASE 16'hfef8
`define EP0_OUT_BASE 16'hfef0
`define EP0_BUF_LEN 7'h08
`define BUF_WINDOW 16'hf800
`endif

/* design/usb_in_ep_pkg.sv */
// types of the endpoint descriptor block
package usb_in_ep_pkg;
    typedef enum logic [1:0] {
        RESP_NONE,
        RESP_DATA,
        RESP_NAK,
        RESP_STALL
    } resp_t;
    typedef struct packed {
        logic [3:1][7:0] x_base;
        logic [3:1][7:0] x_count;
        logic [3:1][7:0] y_base;
        logic [3:1][7:0] y_count;
        logic [3:1][7:0] size;
        logic [3:1][7:0] cfg;
        logic [7:0] ep0_in_cfg;
        logic [7:0] ep0_in_cnt;
        logic [7:0] ep0_out_cfg;
        logic [7:0] ep0_out_cnt;
        logic resp_valid;
        resp_t resp_code;
        logic [15:0] resp_addr;
        logic [6:0] resp_len;
        logic resp_toggle;
        logic done_irq;
    } state_t;
endpackage

/* design/usb_in_ep_desc.sv */
// endpoint descriptor registers and buffer manager answers
`timescale 1ns/1ps
`default_nettype none
`include "usb_in_ep_cfg.svh"
module usb_in_ep_desc
    import usb_in_ep_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // buffer manager requests
    input wire logic bm_req,
    input wire logic bm_ack,
    input wire logic bm_out,
    input wire logic [1:0] bm_ep,
    input wire logic [6:0] bm_out_len,
    input wire logic bm_setup,
    // buffer manager answers
    output logic resp_valid,
    output resp_t resp_code,
    output logic [15:0] resp_addr,
    output logic [6:0] resp_len,
    output logic resp_toggle,
    output logic done_irq
);
    // ==========================================================
    // address decode
    state_t cur;
    state_t next_cur;
    logic acc;
    logic wr;
    logic hit_in_cfg;
    logic hit_in_cnt;
    logic hit_out_cfg;
    logic hit_out_cnt;
    logic hit_epn;
    logic [1:0] sel_ep;
    logic [2:0] sel_ofs;
    logic mapped;
    logic [7:0] rd_byte;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign sel_ep = paddr[6:5];
    assign sel_ofs = paddr[4:2];
    assign hit_in_cfg = paddr == {`EP0_IN_CFG_IDX, 2'b00}; // R8
    assign hit_in_cnt = paddr == {`EP0_IN_CNT_IDX, 2'b00}; // R8
    assign hit_out_cfg = paddr == {`EP0_OUT_CFG_IDX, 2'b00}; // R9
    assign hit_out_cnt = paddr == {`EP0_OUT_CNT_IDX, 2'b00}; // R9
    assign hit_epn = paddr[`APB_AW-1:7] == `EPN_PAGE && sel_ep != 2'b00
        && sel_ofs <= `OFS_CFG && paddr[1:0] == 2'b00;

    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        if (hit_in_cfg) begin
            rd_byte = cur.ep0_in_cfg;
        end else if (hit_in_cnt) begin
            rd_byte = cur.ep0_in_cnt;
        end else if (hit_out_cfg) begin
            rd_byte = cur.ep0_out_cfg;
        end else if (hit_out_cnt) begin
            rd_byte = cur.ep0_out_cnt;
        end else if (hit_epn && sel_ofs == `OFS_X_BASE) begin
            rd_byte = cur.x_base[sel_ep];
        end else if (hit_epn && sel_ofs == `OFS_X_CNT) begin
            rd_byte = cur.x_count[sel_ep];
        end else if (hit_epn && sel_ofs == `OFS_Y_BASE) begin
            rd_byte = cur.y_base[sel_ep];
        end else if (hit_epn && sel_ofs == `OFS_Y_CNT) begin
            rd_byte = cur.y_count[sel_ep];
        end else if (hit_epn && sel_ofs == `OFS_SIZE) begin
            rd_byte = cur.size[sel_ep];
        end else if (hit_epn) begin
            rd_byte = cur.cfg[sel_ep];
        end else begin
            mapped = 1'b0;
        end
    end

    // zero wait states; unmapped access answers with an error
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = {24'h00_0000, rd_byte};

    // ==========================================================
    // descriptor lookup for the requested endpoint
    logic [7:0] q_cfg;
    logic q_use_y;
    logic [7:0] q_cnt;
    logic [7:0] q_base;
    logic [6:0] q_size;

    always_comb begin
        q_cfg = 8'h00;
        q_use_y = 1'b0;
        q_cnt = 8'h00;
        q_base = 8'h00;
        q_size = 7'h00;
        if (bm_ep == 2'b00) begin
            q_cfg = bm_out ? cur.ep0_out_cfg : cur.ep0_in_cfg;
            q_cnt = bm_out ? cur.ep0_out_cnt : cur.ep0_in_cnt;
        end else begin
            q_cfg = cur.cfg[bm_ep];
            q_use_y = q_cfg[`BIT_DOUBLE_BUFFER_ENABLE] && q_cfg[`BIT_TOG]; // R17
            q_cnt = q_use_y ? cur.y_count[bm_ep] : cur.x_count[bm_ep];
            q_base = q_use_y ? cur.y_base[bm_ep] : cur.x_base[bm_ep];
            q_size = cur.size[bm_ep][6:0]; // R6
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_cur = cur;
        next_cur.resp_valid = 1'b0;
        next_cur.resp_code = RESP_NONE;
        next_cur.done_irq = 1'b0;

        // setup clear first so a software set in the same cycle wins
        if (bm_setup) begin
            next_cur.ep0_in_cfg[`BIT_STALL] = 1'b0; // R12
        end

        // register writes; base fields have no other writer
        if (wr && hit_in_cfg) begin
            next_cur.ep0_in_cfg = (cur.ep0_in_cfg & ~`EP0_CFG_WMASK) | (pwdata[7:0] & `EP0_CFG_WMASK); // R13 R16
            if (bm_setup && !pwdata[`BIT_STALL]) begin
                next_cur.ep0_in_cfg[`BIT_STALL] = 1'b0;
            end
        end else if (wr && hit_in_cnt) begin
            next_cur.ep0_in_cnt = pwdata[7:0] & `EP0_CNT_WMASK;
        end else if (wr && hit_out_cfg) begin
            next_cur.ep0_out_cfg = (cur.ep0_out_cfg & ~`EP0_CFG_WMASK) | (pwdata[7:0] & `EP0_CFG_WMASK);
        end else if (wr && hit_out_cnt) begin
            next_cur.ep0_out_cnt = pwdata[7:0] & `EP0_CNT_WMASK;
        end else if (wr && hit_epn && sel_ofs == `OFS_X_BASE) begin
            next_cur.x_base[sel_ep] = pwdata[7:0]; // R5
        end else if (wr && hit_epn && sel_ofs == `OFS_X_CNT) begin
            next_cur.x_count[sel_ep] = pwdata[7:0]; // R1
        end else if (wr && hit_epn && sel_ofs == `OFS_Y_BASE) begin
            next_cur.y_base[sel_ep] = pwdata[7:0]; // R5
        end else if (wr && hit_epn && sel_ofs == `OFS_Y_CNT) begin
            next_cur.y_count[sel_ep] = pwdata[7:0]; // R1
        end else if (wr && hit_epn && sel_ofs == `OFS_SIZE) begin
            next_cur.size[sel_ep] = pwdata[7:0] & `SIZE_WMASK; // R6
        end else if (wr && hit_epn) begin
            next_cur.cfg[sel_ep] = pwdata[7:0] & `EPN_CFG_WMASK;
        end

        // answer a token one cycle later; out tokens only exist on ep0
        if (bm_req && (bm_ep == 2'b00 || !bm_out)) begin
            next_cur.resp_toggle = q_cfg[`BIT_TOG]; // R13
            next_cur.resp_len = 7'h00;
            next_cur.resp_addr = 16'h0000;
            if (!q_cfg[`BIT_EN]) begin
                next_cur.resp_code = RESP_NONE; // R14
            end else if (q_cfg[`BIT_STALL]) begin
                next_cur.resp_valid = 1'b1;
                next_cur.resp_code = RESP_STALL; // R11
            // flag at 1 means no room either way: in buffer empty, out buffer still held
            end else if (q_cnt[`BIT_NAK]) begin
                next_cur.resp_valid = 1'b1;
                next_cur.resp_code = RESP_NAK; // R2 R19
            end else if (bm_ep == 2'b00) begin
                next_cur.resp_valid = 1'b1;
                next_cur.resp_code = RESP_DATA;
                next_cur.resp_addr = bm_out ? `EP0_OUT_BASE : `EP0_IN_BASE; // R7
                next_cur.resp_len = bm_out ? `EP0_BUF_LEN : {3'b000, q_cnt[3:0]};
            end else begin
                next_cur.resp_valid = 1'b1;
                next_cur.resp_code = RESP_DATA;
                next_cur.resp_addr = `BUF_WINDOW | {5'b00000, q_base, 3'b000}; // R3 R4
                // counts beyond the buffer size are cut to the size
                next_cur.resp_len = (q_cnt[6:0] > q_size) ? q_size : q_cnt[6:0]; // R1 R6
            end
        end

        // completion; the hardware set of the ready flag wins over a write
        if (bm_ack && bm_ep == 2'b00 && !bm_out) begin
            next_cur.ep0_in_cnt[`BIT_NAK] = 1'b1; // R20
            next_cur.ep0_in_cfg[`BIT_TOG] = !cur.ep0_in_cfg[`BIT_TOG]; // R13
            next_cur.done_irq = cur.ep0_in_cfg[`BIT_IE]; // R10
        end else if (bm_ack && bm_ep == 2'b00) begin
            next_cur.ep0_out_cnt = {1'b1, 3'b000, bm_out_len[3:0]}; // R19
            next_cur.ep0_out_cfg[`BIT_TOG] = !cur.ep0_out_cfg[`BIT_TOG];
            next_cur.done_irq = cur.ep0_out_cfg[`BIT_IE]; // R10
        end else if (bm_ack && !bm_out) begin
            if (q_use_y) begin
                next_cur.y_count[bm_ep][`BIT_NAK] = 1'b1; // R20
            end else begin
                next_cur.x_count[bm_ep][`BIT_NAK] = 1'b1; // R20
            end
            next_cur.cfg[bm_ep][`BIT_TOG] = !q_cfg[`BIT_TOG]; // R17
            next_cur.done_irq = q_cfg[`BIT_IE]; // R10
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur <= '0;
            cur.x_count <= {3{`CNT_RST}};
            cur.y_count <= {3{`CNT_RST}};
            cur.ep0_in_cfg <= `CFG_RST; // R16
            cur.ep0_out_cfg <= `CFG_RST;
            cur.ep0_in_cnt <= `CNT_RST; // R18
            cur.ep0_out_cnt <= `CNT_RST; // R19
            cur.resp_code <= RESP_NONE;
        end else begin
            cur <= next_cur;
        end
    end

    assign resp_valid = cur.resp_valid;
    assign resp_code = cur.resp_code;
    assign resp_addr = cur.resp_addr;
    assign resp_len = cur.resp_len;
    assign resp_toggle = cur.resp_toggle;
    assign done_irq = cur.done_irq;

    // ==========================================================
    // assertions
    sequence s_ep0_in_req;
        bm_req && !bm_out && bm_ep == 2'b00;
    endsequence

    sequence s_ep1_y_data;
        bm_req && !bm_out && bm_ep == 2'b01 && cur.cfg[1][`BIT_EN]
            && !cur.cfg[1][`BIT_STALL] && q_use_y && !cur.y_count[1][`BIT_NAK];
    endsequence

    sequence s_epn_in_data;
        bm_req && !bm_out && bm_ep != 2'b00 && q_cfg[`BIT_EN] && !q_cfg[`BIT_STALL] && !q_cnt[`BIT_NAK];
    endsequence

    sequence s_ep0_out_req;
        bm_req && bm_out && bm_ep == 2'b00 && cur.ep0_out_cfg[`BIT_EN] && !cur.ep0_out_cfg[`BIT_STALL];
    endsequence

    a_reset_empty: assert property (@(posedge clk_sys) // R18
        $fell(rst) |-> cur.ep0_in_cnt[`BIT_NAK] && cur.ep0_in_cfg == 8'h00)
        else $error("ep0 in not empty after reset");

    a_stall_answer: assert property (@(posedge clk_sys) disable iff (rst) // R11
        s_ep0_in_req ##0 (cur.ep0_in_cfg[`BIT_EN] && cur.ep0_in_cfg[`BIT_STALL])
            |=> resp_valid && resp_code == RESP_STALL)
        else $error("stall not answered");

    a_setup_clear: assert property (@(posedge clk_sys) disable iff (rst) // R12
        bm_setup && !(wr && hit_in_cfg) |=> !cur.ep0_in_cfg[`BIT_STALL])
        else $error("setup left stall set");

    a_nak_answer: assert property (@(posedge clk_sys) disable iff (rst) // R2
        s_ep0_in_req ##0 (cur.ep0_in_cfg[`BIT_EN] && !cur.ep0_in_cfg[`BIT_STALL]
            && cur.ep0_in_cnt[`BIT_NAK]) |=> resp_code == RESP_NAK)
        else $error("empty buffer not nak");

    a_ep0_base: assert property (@(posedge clk_sys) disable iff (rst) // R7
        s_ep0_in_req ##0 (cur.ep0_in_cfg[`BIT_EN] && !cur.ep0_in_cfg[`BIT_STALL]
            && !cur.ep0_in_cnt[`BIT_NAK])
            |=> resp_code == RESP_DATA && resp_addr == `EP0_IN_BASE)
        else $error("ep0 in base wrong");

    a_y_address: assert property (@(posedge clk_sys) disable iff (rst) // R3
        s_ep1_y_data |=> resp_code == RESP_DATA && resp_addr[10:3] == $past(cur.y_base[1])
            && resp_addr[2:0] == 3'b000)
        else $error("y buffer address wrong");

    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R14
        s_ep0_in_req ##0 !cur.ep0_in_cfg[`BIT_EN] |=> !resp_valid)
        else $error("disabled endpoint answered");

    a_ack_empty: assert property (@(posedge clk_sys) disable iff (rst) // R20
        bm_ack && !bm_out && bm_ep == 2'b00
            |=> cur.ep0_in_cnt[`BIT_NAK] && cur.ep0_in_cfg[`BIT_TOG] != $past(cur.ep0_in_cfg[`BIT_TOG]))
        else $error("ack did not empty buffer");

    a_irq_gate: assert property (@(posedge clk_sys) disable iff (rst) // R10
        bm_ack && !bm_out && bm_ep == 2'b00
            |=> done_irq == $past(cur.ep0_in_cfg[`BIT_IE]) ##1 (!done_irq || $past(bm_ack)))
        else $error("completion interrupt wrong");

    a_rsv_zero: assert property (@(posedge clk_sys) disable iff (rst) // R16
        (cur.ep0_in_cfg & 8'h53) == 8'h00 && (cur.ep0_in_cnt & 8'h70) == 8'h00)
        else $error("reserved bit set");

    a_toggle_ro: assert property (@(posedge clk_sys) disable iff (rst) // R13
        wr && hit_in_cfg && !bm_ack |=> $stable(cur.ep0_in_cfg[`BIT_TOG]))
        else $error("software changed toggle");

    a_base_hold: assert property (@(posedge clk_sys) disable iff (rst) // R5
        !wr |=> $stable(cur.y_base) && $stable(cur.x_base))
        else $error("base changed without write");

    // out side of endpoint 0; length clamp and buffer choice on endpoints 1 to 3, completion on endpoint 1
    a_out_nak: assert property (@(posedge clk_sys) disable iff (rst) // R19
        s_ep0_out_req ##0 cur.ep0_out_cnt[`BIT_NAK] |=> resp_valid && resp_code == RESP_NAK)
        else $error("held out packet not nak");

    a_out_data: assert property (@(posedge clk_sys) disable iff (rst) // R7
        s_ep0_out_req ##0 !cur.ep0_out_cnt[`BIT_NAK]
            |=> resp_code == RESP_DATA && resp_addr == `EP0_OUT_BASE)
        else $error("ep0 out base wrong");

    a_out_store: assert property (@(posedge clk_sys) disable iff (rst) // R19
        bm_ack && bm_out && bm_ep == 2'b00
            |=> cur.ep0_out_cnt == {1'b1, 3'b000, $past(bm_out_len[3:0])})
        else $error("out packet not marked held");

    a_len_clamp: assert property (@(posedge clk_sys) disable iff (rst) // R6
        s_epn_in_data |=> resp_code == RESP_DATA && resp_len <= $past(q_size))
        else $error("in length beyond buffer size");

    a_x_select: assert property (@(posedge clk_sys) disable iff (rst) // R17
        s_epn_in_data ##0 !(q_cfg[`BIT_DOUBLE_BUFFER_ENABLE] && q_cfg[`BIT_TOG])
            |=> resp_addr[10:3] == $past(cur.x_base[bm_ep]) && resp_addr[2:0] == 3'b000)
        else $error("x buffer not used");

    a_epn_ack: assert property (@(posedge clk_sys) disable iff (rst) // R20
        bm_ack && !bm_out && bm_ep == 2'b01 && !q_use_y |=> cur.x_count[1][`BIT_NAK])
        else $error("x buffer not emptied");

    // only software may clear the ready flag; software or a setup may clear stall
    a_ready_hold: assert property (@(posedge clk_sys) disable iff (rst) // R2
        !(wr && hit_in_cnt) |=> !$fell(cur.ep0_in_cnt[`BIT_NAK]))
        else $error("ready flag cleared by hardware");

    a_stall_hold: assert property (@(posedge clk_sys) disable iff (rst) // R11
        !bm_setup && !(wr && hit_in_cfg) |=> !$fell(cur.ep0_in_cfg[`BIT_STALL]))
        else $error("stall dropped without setup");

endmodule // usb_in_ep_desc
`default_nettype wire

/* verif/usb_host_model.sv */
// host side model issuing token, completion and setup pulses
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import usb_in_ep_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // requests towards the block
    output var logic bm_req,
    output var logic bm_ack,
    output var logic bm_out,
    output var logic [1:0] bm_ep,
    output var logic [6:0] bm_out_len,
    output var logic bm_setup,
    // answers from the block
    input wire logic resp_valid,
    input wire resp_t resp_code,
    input wire logic [15:0] resp_addr,
    input wire logic [6:0] resp_len,
    input wire logic done_irq
);
    initial begin
        bm_req = 1'b0;
        bm_ack = 1'b0;
        bm_out = 1'b0;
        bm_ep = 2'h0;
        bm_out_len = 7'h00;
        bm_setup = 1'b0;
    end
    // ====================
    // token: answer is looked at in the single cycle it stands
    task automatic token(input logic [1:0] ep, input logic o, output resp_t c, output logic [15:0] a,
                         output logic [6:0] l);
        @(posedge clk_sys);
        bm_req <= 1'b1;
        bm_ep <= ep;
        bm_out <= o;
        @(posedge clk_sys);
        bm_req <= 1'b0;
        bm_ep <= ~ep;
        bm_out <= ~o;
        @(negedge clk_sys);
        c = (resp_valid === 1'b1) ? resp_code : RESP_NONE;
        a = resp_addr;
        l = resp_len;
    endtask
    // ====================
    task automatic ack(input logic [1:0] ep, input logic o, input logic [6:0] len, output logic irq);
        @(posedge clk_sys);
        bm_ack <= 1'b1;
        bm_ep <= ep;
        bm_out <= o;
        bm_out_len <= len;
        @(posedge clk_sys);
        bm_ack <= 1'b0;
        bm_ep <= ~ep;
        bm_out_len <= ~len;
        @(negedge clk_sys);
        irq = done_irq;
    endtask
    task automatic setup();
        @(posedge clk_sys);
        bm_setup <= 1'b1;
        @(posedge clk_sys);
        bm_setup <= 1'b0;
    endtask
endmodule // usb_host_model
`default_nettype wire

/* verif/usb_in_endpoint_descriptors_bench.sv */
// self-checking bench for the endpoint descriptor block
`timescale 1ns/1ps
`default_nettype none
module usb_in_endpoint_descriptors_bench;
    import usb_in_ep_pkg::*;
    logic clk_sys;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bm_req, bm_ack, bm_out, bm_setup, resp_valid, done_irq, resp_toggle;
    logic [1:0] bm_ep;
    logic [6:0] bm_out_len, resp_len;
    logic [15:0] resp_addr;
    resp_t resp_code;
    int miscompares = 0;
    int n_compared = 0;
    usb_in_ep_desc u_usb_in_ep_desc (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bm_req(bm_req), .bm_ack(bm_ack), .bm_out(bm_out), .bm_ep(bm_ep),
        .bm_out_len(bm_out_len), .bm_setup(bm_setup), .resp_valid(resp_valid), .resp_code(resp_code),
        .resp_addr(resp_addr), .resp_len(resp_len), .resp_toggle(resp_toggle), .done_irq(done_irq));
    usb_host_model u_usb_host_model (.clk_sys(clk_sys), .bm_req(bm_req), .bm_ack(bm_ack),
        .bm_out(bm_out), .bm_ep(bm_ep), .bm_out_len(bm_out_len), .bm_setup(bm_setup),
        .resp_valid(resp_valid), .resp_code(resp_code), .resp_addr(resp_addr), .resp_len(resp_len),
        .done_irq(done_irq));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ====================
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // ====================
    // apb master, request held until pready is seen high
    task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        if (i == 16) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rd(input string n, input logic [17:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 8'h00, r, e);
        chk(n, {24'h00_0000, x}, r);
    endtask
    task automatic tok(input string n, input logic [1:0] ep, input logic o, input resp_t xc,
                       input logic [15:0] xa, input logic [6:0] xl);
        resp_t c;
        logic [15:0] a;
        logic [6:0] l;
        u_usb_host_model.token(ep, o, c, a, l);
        chk(n, {30'h0, xc}, {30'h0, c});
        if (xc == RESP_DATA) begin
            chk(n, {16'h0000, xa}, {16'h0000, a});
            chk(n, {25'h0, xl}, {25'h0, l});
        end
    endtask
    // ====================
    task automatic sc_reset();
        logic [31:0] r;
        logic e;
        rd("in_cfg", 18'h3_fe00, 8'h00);
        rd("in_cnt", 18'h3_fe04, 8'h80);
        rd("out_cfg", 18'h3_fe08, 8'h00);
        rd("out_cnt", 18'h3_fe0c, 8'h80);
        apb(18'h0_0004, 1'b0, 8'h00, r, e);
        chk("unmapped", 32'h0000_0001, {31'h0, e});
        tok("off", 2'h0, 1'b0, RESP_NONE, 16'h0000, 7'h00);
    endtask
    task automatic sc_ep0_in();
        logic irq;
        wr(18'h3_fe00, 8'hff);
        rd("in_cfg_mask", 18'h3_fe00, 8'h8c);
        wr(18'h3_fe00, 8'h84);
        tok("empty", 2'h0, 1'b0, RESP_NAK, 16'h0000, 7'h00);
        wr(18'h3_fe04, 8'h08);
        tok("in_data", 2'h0, 1'b0, RESP_DATA, 16'hfef8, 7'h08);
        chk("in_tog", 32'h0000_0000, {31'h0, resp_toggle});
        u_usb_host_model.ack(2'h0, 1'b0, 7'h00, irq);
        chk("irq_on", 32'h0000_0001, {31'h0, irq});
        rd("in_cnt_done", 18'h3_fe04, 8'h88);
        rd("in_toggle", 18'h3_fe00, 8'ha4);
        wr(18'h3_fe00, 8'h80);
        u_usb_host_model.ack(2'h0, 1'b0, 7'h00, irq);
        chk("irq_off", 32'h0000_0000, {31'h0, irq});
        rd("in_toggle2", 18'h3_fe00, 8'h80);
    endtask
    task automatic sc_stall();
        wr(18'h3_fe00, 8'h88);
        tok("stall", 2'h0, 1'b0, RESP_STALL, 16'h0000, 7'h00);
        u_usb_host_model.setup();
        rd("stall_clr", 18'h3_fe00, 8'h80);
        tok("after_setup", 2'h0, 1'b0, RESP_NAK, 16'h0000, 7'h00);
    endtask
    task automatic sc_ep0_out();
        logic irq;
        wr(18'h3_fe08, 8'h80);
        wr(18'h3_fe0c, 8'h00);
        tok("out_data", 2'h0, 1'b1, RESP_DATA, 16'hfef0, 7'h08);
        u_usb_host_model.ack(2'h0, 1'b1, 7'h05, irq);
        rd("out_cnt_full", 18'h3_fe0c, 8'h85);
        tok("out_full", 2'h0, 1'b1, RESP_NAK, 16'h0000, 7'h00);
    endtask
    task automatic sc_epn();
        logic irq;
        wr(18'h0_0128, 8'h12);
        wr(18'h0_012c, 8'h40);
        wr(18'h0_0130, 8'hff);
        rd("size_rsv", 18'h0_0130, 8'h7f);
        wr(18'h0_0130, 8'h20);
        wr(18'h0_0124, 8'h80);
        wr(18'h0_0134, 8'hb0);
        tok("y_data", 2'h1, 1'b0, RESP_DATA, 16'hf890, 7'h20);
        chk("y_tog", 32'h0000_0001, {31'h0, resp_toggle});
        u_usb_host_model.ack(2'h1, 1'b0, 7'h00, irq);
        rd("y_cnt_done", 18'h0_012c, 8'hc0);
        rd("y_base_kept", 18'h0_0128, 8'h12);
        tok("x_empty", 2'h1, 1'b0, RESP_NAK, 16'h0000, 7'h00);
        wr(18'h0_0120, 8'h20);
        wr(18'h0_0124, 8'h05);
        tok("x_data", 2'h1, 1'b0, RESP_DATA, 16'hf900, 7'h05);
        chk("x_tog", 32'h0000_0000, {31'h0, resp_toggle});
        u_usb_host_model.ack(2'h1, 1'b0, 7'h00, irq);
        rd("x_cnt_done", 18'h0_0124, 8'h85);
        chk("x_irq", 32'h0000_0000, {31'h0, irq});
    endtask
    // ====================
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0_0000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        sc_reset();
        sc_ep0_in();
        sc_stall();
        sc_ep0_out();
        sc_epn();
        final_report();
    end
endmodule // usb_in_endpoint_descriptors_bench
`default_nettype wire
